/* File: dv/timer_pulse_generator_bench.sv */
// Self-checking bench for the timer/pulse generator
`timescale 1ns/1ps
module timer_pulse_generator_bench;
    import pulse_gen_pkg::*;
    // ========================================================
    // Stimulus and observation
    logic        clk_i       = 1'b0;
    logic        reset_i     = 1'b1;
    logic        wr_i        = 1'b0;
    logic        bit_wr_i    = 1'b0;
    logic        bit_val_i   = 1'b0;
    logic        irq_clear_i = 1'b0;
    logic [11:0] addr_i      = 12'h000;
    logic [7:0]  wdata_i     = 8'h00;
    logic [2:0]  bit_sel_i   = 3'h0;
    logic [7:0]  mode;
    logic [7:0]  count;
    logic        flag;
    logic        irq;
    logic        pin;
    logic        oe;
    logic        p0;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          n;
    int          lo;

    timer_pulse_generator uut (
        .clk_i              (clk_i),
        .reset_i            (reset_i),
        .addr_i             (addr_i),
        .wdata_i            (wdata_i),
        .wr_i               (wr_i),
        .bit_wr_i           (bit_wr_i),
        .bit_sel_i          (bit_sel_i),
        .bit_val_i          (bit_val_i),
        .irq_clear_i        (irq_clear_i),
        .pulse_gen_mode_o   (mode),
        .count_o            (count),
        .gen_irq_flag_o     (flag),
        .gen_irq_signal_o   (irq),
        .pulse_out_pin_o    (pin),
        .pulse_out_pin_oe_o (oe)
    );

    // ========================================================
    // Access tasks; every task leaves us 1 ns after a rising edge
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        addr_i  = a;
        wdata_i = d;
        wr_i    = 1'b1;
        cyc(1);
        wr_i = 1'b0;
        cyc(1);
    endtask

    task automatic bwr(input logic [2:0] s, input logic v);
        addr_i    = PULSE_GEN_MODE_ADDR;
        bit_sel_i = s;
        bit_val_i = v;
        bit_wr_i  = 1'b1;
        cyc(1);
        bit_wr_i = 1'b0;
        cyc(1);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rng(input int got, input int lo_b, input int hi_b);
        tests_run++;
        if (got < lo_b || got > hi_b) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, lo_b);
        end
    endtask

    // Bounded wait; n stays at lim if the pulse never comes
    task automatic wait_irq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
    endtask

    // Low cycles of the active-low pin over one basic period
    task automatic low_cnt();
        lo = 0;
        repeat (1024) begin
            cyc(1);
            if (pin === 1'b0) lo++;
        end
    endtask

    task automatic stop_test();
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ========================================================
    // Clock, watchdog and test sequence
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // Tests need about 76k cycles, mostly two 2^15 PWM periods
    initial begin
        repeat (90000) @(posedge clk_i);
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        cyc(1);
        chk(mode, 8'h00);
        chk({oe, flag, irq, count}, 32'h0);
        wr(12'hf91, 8'hff);
        chk(mode, 8'h00);
        wr(PULSE_GEN_MODE_ADDR, 8'hff);
        chk(mode, 8'hbb);
        bwr(3'd3, 1'b0);
        chk(mode, 8'hb3);
        bwr(3'd5, 1'b0);
        chk(mode, 8'hb3);
        bwr(3'd3, 1'b1);
        chk(mode, 8'hbb);
        wr(PULSE_GEN_MODE_ADDR, 8'h90);
        chk({oe, pin}, 2'b11);
        wr(PULSE_GEN_MODE_ADDR, 8'h80);
        chk({oe, pin}, 2'b10);
        wr(PULSE_GEN_MODE_ADDR, 8'h30);
        chk(oe, 1'b0);
        // Each prescale source with N=1: interval is 2 * divider
        for (int i = 2; i <= 6; i++) begin
            wr(PULSE_GEN_MODE_ADDR, 8'h00);
            wr(PRESCALE_LOW_ADDR, 8'h01 << i);
            wr(INTERVAL_HIGH_ADDR, 8'h01);
            wr(PULSE_GEN_MODE_ADDR, 8'hbb);
            wait_irq(600);
            cyc(1);
            chk(flag, 1'b1);
            p0 = pin;
            wait_irq(600);
            chk(count, 8'h00);
            chk(n + 1, 2 * (256 >> (i - 2)));
            cyc(1);
            chk(pin, !p0);
        end
        wr(PULSE_GEN_MODE_ADDR, 8'h9b);
        chk(pin, 1'b1);
        // Stop first, then clear the flag left set by the earlier timer matches
        wr(PULSE_GEN_MODE_ADDR, 8'h00);
        irq_clear_i = 1'b1;
        cyc(1);
        irq_clear_i = 1'b0;
        cyc(1);
        chk({flag, count}, 32'h0);
        wait_irq(600);
        chk(n, 600);
        wr(INTERVAL_HIGH_ADDR, 8'h40);
        wr(PULSE_GEN_MODE_ADDR, 8'haa);
        wait_irq(33000);
        cyc(1);
        wait_irq(33000);
        chk(n + 1, 32768);
        low_cnt();
        rng(lo, 256, 258);
        // Latch must hold its old value while reload is off
        bwr(3'd3, 1'b0);
        wr(INTERVAL_HIGH_ADDR, 8'h80);
        cyc(2048);
        low_cnt();
        rng(lo, 256, 258);
        bwr(3'd3, 1'b1);
        cyc(2048);
        low_cnt();
        rng(lo, 512, 514);
        wr(PULSE_GEN_MODE_ADDR, 8'h00);
        chk({mode, oe}, 9'h000);
        stop_test();
    end
endmodule // timer_pulse_generator_bench

/* File: hw/pulse_gen_pkg.sv */
// Package of constants for the timer/pulse generator
package pulse_gen_pkg;
    // ========================================================
    // Register map
    localparam logic [11:0] PULSE_GEN_MODE_ADDR  = 12'hf90;
    localparam logic [11:0] PRESCALE_LOW_ADDR    = 12'hf92;
    localparam logic [11:0] INTERVAL_HIGH_ADDR   = 12'hf94;
    localparam logic [7:0]  PULSE_GEN_MODE_RESET = 8'h00;
    localparam logic [7:0]  MOD_REG_RESET        = 8'h00;
    localparam logic [7:0]  MODE_WRITE_MASK      = 8'hbb;
    // ========================================================
    // Mode register fields
    localparam int MODE_SELECT_POS  = 0;
    localparam int RUN_ENABLE_POS   = 1;
    localparam int RELOAD_POS       = 3;
    localparam int STATIC_LEVEL_POS = 4;
    localparam int PULSE_SELECT_POS = 5;
    localparam int PIN_DRIVE_POS    = 7;
    // ========================================================
    // Prescaler: one-hot select in low modulo bits 2..6
    localparam int PRESCALE_SEL_LSB = 2;
    localparam int PRESCALE_WIDTH   = 8;
    // ========================================================
    // PWM timing in main clock cycles
    localparam int PWM_LATCH_WIDTH  = 14;
    localparam int PWM_BASE_BITS    = 10;
    localparam int PWM_PERIOD_BITS  = 15;
endpackage

/* File: hw/pwm_pulse_unit.sv */
// PWM pulse generator with low-active output and periodic event
`timescale 1ns/1ps
module pwm_pulse_unit
    import pulse_gen_pkg::*;
(
    input  wire logic                       clk_i,      // System clock
    input  wire logic                       reset_i,    // Sync reset
    input  wire logic                       run_i,      // Generator running
    input  wire logic [PWM_LATCH_WIDTH-1:0] duty_i,     // Modulo latch value
    output logic                            pwm_o,      // Active-low pulse
    output logic                            period_o    // One pulse per 2^15
);
    logic [PWM_PERIOD_BITS-1:0] phase;
    logic [PWM_PERIOD_BITS-1:0] next_phase;
    logic                       next_pwm;
    logic                       next_period;
    logic [PWM_BASE_BITS:0]     low_width;

    // Spread the 14-bit value: 8 upper bits set the base low width,
    // the 6 lower bits, divided by 4 and rounded up, add one extra cycle in that many of 32 sub-periods.
    // That keeps the ripple at the base period for the external filter.
    always_comb begin
        next_phase  = run_i ? phase + 1'b1 : '0;
        low_width   = {1'b0, duty_i[13:6], 2'b00}
                      + {{(PWM_BASE_BITS){1'b0}},
                         (phase[14:10] < {1'b0, duty_i[5:2]} + 5'(duty_i[1:0] != 2'b00))};
        next_pwm    = !(run_i && ({1'b0, phase[9:0]} < low_width));
        next_period = run_i && (phase == {PWM_PERIOD_BITS{1'b1}});
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phase    <= '0;
            pwm_o    <= 1'b1;
            period_o <= 1'b0;
        end else begin
            phase    <= next_phase;
            pwm_o    <= next_pwm;
            period_o <= next_period;
        end
    end

    a_period_spacing: assert property (@(posedge clk_i) disable iff (reset_i)
        period_o |=> !period_o) else $error("Period pulse too long");
    a_idle_high: assert property (@(posedge clk_i) disable iff (reset_i)
        !run_i |=> pwm_o) else $error("PWM low while stopped");
endmodule // pwm_pulse_unit

/* File: hw/timer_pulse_generator.sv */
// Timer/pulse generator: mode register, modulo registers, timer and PWM
`timescale 1ns/1ps
module timer_pulse_generator
    import pulse_gen_pkg::*;
(
    input  wire logic        clk_i,          // System clock, 200 MHz
    input  wire logic        reset_i,        // Sync reset, active high
    input  wire logic [11:0] addr_i,         // Data memory address
    input  wire logic [7:0]  wdata_i,        // Write data
    input  wire logic        wr_i,           // 8-bit write strobe
    input  wire logic        bit_wr_i,       // Single-bit write strobe
    input  wire logic [2:0]  bit_sel_i,      // Bit number for bit write
    input  wire logic        bit_val_i,      // Value for bit write
    input  wire logic        irq_clear_i,    // Clear interrupt flag
    output logic [7:0]       pulse_gen_mode_o, // Mode register readback
    output logic [7:0]       count_o,        // Count register view
    output logic             gen_irq_flag_o, // Interrupt request flag
    output logic             gen_irq_signal_o, // One-cycle set pulse
    output logic             pulse_out_pin_o, // Pin level
    output logic             pulse_out_pin_oe_o // Pin drive enable
);
    // ========================================================
    // Registers
    logic [7:0]  pulse_gen_mode, next_mode;
    logic [7:0]  prescale_reg_low, next_low;
    logic [7:0]  interval_reg_high, next_high;
    logic [7:0]  latch_high, next_latch_high;
    logic [5:0]  latch_low, next_latch_low;
    logic [7:0]  prescaler, next_prescaler;
    logic [7:0]  count, next_count;
    logic        square_ff, next_square;
    logic        irq_flag, next_irq_flag;
    logic        irq_pulse, next_irq_pulse;
    logic        pin, next_pin;
    logic        pin_oe, next_pin_oe;
    logic        tick, match;
    logic        timer_mode, running;
    logic        pwm_level, pwm_period;

    assign timer_mode = pulse_gen_mode[MODE_SELECT_POS];
    assign running    = pulse_gen_mode[RUN_ENABLE_POS];

    pwm_pulse_unit u_pwm (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .run_i    (running && !timer_mode),
        .duty_i   ({latch_high, latch_low}),
        .pwm_o    (pwm_level),
        .period_o (pwm_period)
    );

    // ========================================================
    // Register writes and reload
    always_comb begin
        next_mode = pulse_gen_mode;
        next_low  = prescale_reg_low;
        next_high = interval_reg_high;
        if (wr_i && addr_i == PULSE_GEN_MODE_ADDR)
            next_mode = wdata_i & MODE_WRITE_MASK;
        // A bit write lands after a byte write, so it wins bit 3
        if (bit_wr_i && addr_i == PULSE_GEN_MODE_ADDR && bit_sel_i == 3'(RELOAD_POS))
            next_mode[RELOAD_POS] = bit_val_i;
        if (wr_i && addr_i == PRESCALE_LOW_ADDR)
            next_low = wdata_i;
        if (wr_i && addr_i == INTERVAL_HIGH_ADDR)
            next_high = wdata_i;
        next_latch_high = latch_high;
        next_latch_low  = latch_low;
        // Latch copies every cycle while reload is on; clear it while
        // rewriting both halves so PWM never sees half of an update
        if (pulse_gen_mode[RELOAD_POS]) begin
            next_latch_high = interval_reg_high;
            next_latch_low  = prescale_reg_low[7:2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pulse_gen_mode    <= PULSE_GEN_MODE_RESET;
            prescale_reg_low  <= MOD_REG_RESET;
            interval_reg_high <= MOD_REG_RESET;
            latch_high        <= MOD_REG_RESET;
            latch_low         <= '0;
        end else begin
            pulse_gen_mode    <= next_mode;
            prescale_reg_low  <= next_low;
            interval_reg_high <= next_high;
            latch_high        <= next_latch_high;
            latch_low         <= next_latch_low;
        end
    end

    // ========================================================
    // Interval timer
    always_comb begin
        next_prescaler = (running && timer_mode) ? prescaler + 8'h01 : 8'h00;
        // Prescale bit k divides by 2^(10-k): bit2 /256 ... bit6 /16
        tick = running && timer_mode && (
               (latch_low[0] && prescaler == 8'hff) ||
               (latch_low[1] && prescaler[6:0] == 7'h7f) ||
               (latch_low[2] && prescaler[5:0] == 6'h3f) ||
               (latch_low[3] && prescaler[4:0] == 5'h1f) ||
               (latch_low[4] && prescaler[3:0] == 4'hf));
        match = tick && (count == latch_high);
        next_count  = count;
        next_square = square_ff;
        // Stopping clears counter and prescaler, never the flag
        if (!running || !timer_mode) begin
            next_count = 8'h00;
        end else if (match) begin
            next_count  = 8'h00;
            next_square = !square_ff;
        end else if (tick) begin
            next_count = count + 8'h01;
        end
        next_irq_pulse = match || (running && !timer_mode && pwm_period);
        // Set beats a simultaneous clear
        next_irq_flag  = next_irq_pulse || (irq_flag && !irq_clear_i);
        // Pin lags its source by one flop so the output is registered
        next_pin_oe    = pulse_gen_mode[PIN_DRIVE_POS];
        if (!pulse_gen_mode[PULSE_SELECT_POS])
            next_pin = pulse_gen_mode[STATIC_LEVEL_POS];
        else if (timer_mode)
            next_pin = square_ff;
        else
            next_pin = pwm_level;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prescaler <= 8'h00;
            count     <= 8'h00;
            square_ff <= 1'b0;
            irq_flag  <= 1'b0;
            irq_pulse <= 1'b0;
            pin       <= 1'b0;
            pin_oe    <= 1'b0;
        end else begin
            prescaler <= next_prescaler;
            count     <= next_count;
            square_ff <= next_square;
            irq_flag  <= next_irq_flag;
            irq_pulse <= next_irq_pulse;
            pin       <= next_pin;
            pin_oe    <= next_pin_oe;
        end
    end

    assign pulse_gen_mode_o   = pulse_gen_mode;
    assign count_o            = count;
    assign gen_irq_flag_o     = irq_flag;
    assign gen_irq_signal_o   = irq_pulse;
    assign pulse_out_pin_o    = pin;
    assign pulse_out_pin_oe_o = pin_oe;

    // ========================================================
    // Assertions
    a_mode_select: assert property (@(posedge clk_i) disable iff (reset_i)
        timer_mode |=> !pwm_period) else $error("PWM period active in timer mode");
    a_reload_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        !pulse_gen_mode[RELOAD_POS] |=> $stable(latch_high))
        else $error("Latch moved with reload off");
    a_bit_write: assert property (@(posedge clk_i) disable iff (reset_i)
        (bit_wr_i && !wr_i && addr_i == PULSE_GEN_MODE_ADDR && bit_sel_i == 3'd3)
        |=> pulse_gen_mode[7:4] == $past(pulse_gen_mode[7:4])
            && pulse_gen_mode[RELOAD_POS] == $past(bit_val_i))
        else $error("Bit write disturbed mode register");
    a_stop_halts: assert property (@(posedge clk_i) disable iff (reset_i)
        !running |=> count == 8'h00) else $error("Counter runs while stopped");
    a_match_action: assert property (@(posedge clk_i) disable iff (reset_i)
        match |=> count == 8'h00 && irq_flag && square_ff != $past(square_ff))
        else $error("Match did not clear, toggle and flag");
    a_pin_float: assert property (@(posedge clk_i) disable iff (reset_i)
        !pulse_gen_mode[PIN_DRIVE_POS] |=> !pulse_out_pin_oe_o)
        else $error("Pin driven while disabled");
    a_static_out: assert property (@(posedge clk_i) disable iff (reset_i)
        !pulse_gen_mode[PULSE_SELECT_POS] |=> pin == $past(pulse_gen_mode[STATIC_LEVEL_POS]))
        else $error("Static level not on pin");
    a_count_step: assert property (@(posedge clk_i) disable iff (reset_i)
        (tick && !match) |=> count == $past(count) + 8'h01)
        else $error("Count did not advance");
    a_irq_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        (irq_flag && !irq_clear_i) |=> irq_flag) else $error("Flag lost");
    a_set_wins: assert property (@(posedge clk_i) disable iff (reset_i)
        (next_irq_pulse && irq_clear_i) |=> irq_flag) else $error("Clear beat a new event");
    a_pin_drive: assert property (@(posedge clk_i) disable iff (reset_i)
        pulse_gen_mode[PIN_DRIVE_POS] |=> pulse_out_pin_oe_o)
        else $error("Pin not driven while enabled");
    a_square_route: assert property (@(posedge clk_i) disable iff (reset_i)
        (pulse_gen_mode[PULSE_SELECT_POS] && timer_mode) |=> pin == $past(square_ff))
        else $error("Square wave not on pin");
    a_pwm_route: assert property (@(posedge clk_i) disable iff (reset_i)
        (pulse_gen_mode[PULSE_SELECT_POS] && !timer_mode) |=> pin == $past(pwm_level))
        else $error("PWM wave not on pin");
    a_pwm_event: assert property (@(posedge clk_i) disable iff (reset_i)
        (running && !timer_mode && pwm_period) |=> irq_pulse && irq_flag)
        else $error("PWM period did not raise interrupt");
    a_prescale_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        !running |=> prescaler == 8'h00) else $error("Prescaler runs while stopped");

    // ========================================================
    // Coverage of the main scenarios
    c_timer_match: cover property (@(posedge clk_i) match);
    c_pwm_period: cover property (@(posedge clk_i) running && !timer_mode && pwm_period);
    c_set_clear: cover property (@(posedge clk_i) next_irq_pulse && irq_clear_i);
    c_static_pin: cover property (@(posedge clk_i)
        !pulse_gen_mode[PULSE_SELECT_POS] && pin_oe && pin);
    c_reload_hold: cover property (@(posedge clk_i)
        !pulse_gen_mode[RELOAD_POS] && wr_i && addr_i == INTERVAL_HIGH_ADDR);
endmodule // timer_pulse_generator
